// ==== debug_memory_access_engine_map.svh ====
`ifndef DEBUG_MEMORY_ACCESS_ENGINE_MAP_SVH
`define DEBUG_MEMORY_ACCESS_ENGINE_MAP_SVH
`define IDX_CONTROL        6'h07
`define IDX_ADDRESS        6'h09
`define IDX_DATA           6'h0A
`define ACCESS_CONTROL_BIT 31
`define DIRECTION_BIT      30
`define WORD_SIZE_HI       29
`define WORD_SIZE_LO       27
`define TRANSFER_COUNT_HI  15
`define TRANSFER_COUNT_LO  2
`define ERR_BIT            1
`define DATA_VALID_BIT     0
`define WORD_SIZE_DWORD    3'h3
`define BURST_COUNT        14'h0004
`define ONE_COUNT          14'h0001
`define DWORD_STEP         32'h0000_0008
`define CTRL_RESET         32'h0000_0000
`define TCODE_RW_ERR       6'h08
`define ERROR_CODE_RW      5'h03
`define MSEO_IDLE          2'h3
`define MSEO_START         2'h0
`define RESP_OKAY          2'h0
`define RESP_DECERR        2'h3
`endif

// ==== dmae_pkg.sv ====
package dmae_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS  = 2'b01,
    ST_STEP = 2'b10,
    ST_HOLD = 2'b11
  } engine_state_t;
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [2:0]  size;
  } bus_request_t;
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [63:0] rdata;
  } bus_answer_t;
  typedef struct packed {
    logic [11:0] mdo;
    logic [1:0]  mseo;
  } trace_port_t;
endpackage

// ==== debug_memory_access_engine.sv ====
`timescale 1ns/1ps
`include "debug_memory_access_engine_map.svh"
module debug_memory_access_engine
  import dmae_pkg::*;
#(
  parameter logic [3:0] SOURCE_ID = 4'h5 // Arbitrary value
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // AXI4-Lite write
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  // AXI4-Lite read
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  // System bus
  output bus_request_t      bus_out,
  input  wire bus_answer_t  bus_in,
  // Trace port
  input  wire logic         link_clk,
  output trace_port_t       trace,
  // Ready pin
  output logic              access_ready_n
);

  function automatic logic [7:0] byte_addr(input logic [5:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == byte_addr(`IDX_CONTROL)) || (a == byte_addr(`IDX_ADDRESS)) ||
             (a == byte_addr(`IDX_DATA));
  endfunction

  engine_state_t state;
  logic [31:0]   ctrl_word;
  logic [31:0]   access_address;
  logic [31:0]   access_data;
  logic [63:0]   burst_buffer [0:3];
  logic          access_control_bit;
  logic          err_bit;
  logic          data_valid_bit;
  logic [31:0]   cur_addr;
  logic [13:0]   cur_count;
  logic          burst_mode;
  logic          burst_done;
  logic [1:0]    beat;
  logic [2:0]    read_ptr;
  logic          err_event;
  logic          aw_held;
  logic          w_held;
  logic [7:0]    aw_addr_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic [2:0]    link_sync;
  logic          link_level;
  logic          link_rise;
  logic          trace_pending;
  logic          trace_phase;
  logic          do_write;
  logic          do_read;
  logic          wr_ctrl;
  logic          rd_data;
  logic [31:0]   next_ctrl;
  logic [13:0]   next_count;
  logic [31:0]   step;
  logic [14:0]   err_frame;

  // Control writes wait while a beat is on the bus, so a block ends on a beat boundary
  assign do_write = aw_held && w_held && !bvalid && (state != ST_BUS);
  assign awready  = ce && !aw_held;
  assign wready   = ce && !w_held;
  assign arready  = ce && !rvalid;
  assign do_read  = arvalid && arready;
  assign wr_ctrl  = do_write && (aw_addr_q == byte_addr(`IDX_CONTROL));
  assign rd_data  = do_read && (araddr == byte_addr(`IDX_DATA));
  assign next_ctrl = merge({access_control_bit, ctrl_word[`DIRECTION_BIT:0]}, w_data_q,
                           w_strb_q);
  assign next_count = (next_ctrl[`TRANSFER_COUNT_HI:`TRANSFER_COUNT_LO] <= `ONE_COUNT) ?
                      `ONE_COUNT : next_ctrl[`TRANSFER_COUNT_HI:`TRANSFER_COUNT_LO];
  assign step = burst_mode ? `DWORD_STEP :
                (32'h0000_0001 << ctrl_word[`WORD_SIZE_HI:`WORD_SIZE_LO]);
  assign err_frame = {`ERROR_CODE_RW, SOURCE_ID, `TCODE_RW_ERR};

  assign bus_out.req  = (state == ST_BUS);
  assign bus_out.addr = cur_addr;
  assign bus_out.size = ctrl_word[`WORD_SIZE_HI:`WORD_SIZE_LO];

  // AXI write channel capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // AXI write response
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_DECERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (do_read) begin
        rvalid <= 1'b1;
        rresp  <= mapped(araddr) ? `RESP_OKAY : `RESP_DECERR;
        if (araddr == byte_addr(`IDX_CONTROL)) begin
          rdata <= {access_control_bit, ctrl_word[`DIRECTION_BIT:`TRANSFER_COUNT_LO],
                    err_bit, data_valid_bit};
        end else if (araddr == byte_addr(`IDX_ADDRESS)) begin
          rdata <= access_address;
        end else if (araddr == byte_addr(`IDX_DATA)) begin
          if (burst_done) begin
            rdata <= read_ptr[0] ? burst_buffer[read_ptr[2:1]][63:32] :
                                   burst_buffer[read_ptr[2:1]][31:0];
          end else begin
            rdata <= access_data;
          end
        end else begin
          rdata <= 32'h0000_0000;
        end
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Software-visible setup; the engine never writes these back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_word      <= `CTRL_RESET;
      access_address <= 32'h0000_0000;
    end else if (ce && do_write) begin
      if (aw_addr_q == byte_addr(`IDX_CONTROL)) begin
        ctrl_word <= next_ctrl;
      end
      if (aw_addr_q == byte_addr(`IDX_ADDRESS)) begin
        access_address <= merge(access_address, w_data_q, w_strb_q);
      end
    end
  end

  // Burst buffer needs no reset; only read after a full burst
  always_ff @(posedge clk) begin
    if (ce && state == ST_BUS && bus_in.ack && !bus_in.err && burst_mode) begin
      burst_buffer[beat] <= bus_in.rdata;
    end
  end

  // Access engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state              <= ST_IDLE;
      access_control_bit <= 1'b0;
      err_bit            <= 1'b0;
      data_valid_bit     <= 1'b0;
      access_data        <= 32'h0000_0000;
      cur_addr           <= 32'h0000_0000;
      cur_count          <= 14'h0000;
      burst_mode         <= 1'b0;
      burst_done         <= 1'b0;
      beat               <= 2'h0;
      read_ptr           <= 3'h0;
      access_ready_n     <= 1'b1;
      err_event          <= 1'b0;
    end else if (ce) begin
      err_event <= 1'b0;
      if (wr_ctrl) begin
        err_bit        <= 1'b0;
        data_valid_bit <= 1'b0;
        access_ready_n <= 1'b1;
        burst_done     <= 1'b0;
        beat           <= 2'h0;
        read_ptr       <= 3'h0;
        cur_addr       <= access_address;
        cur_count      <= next_count;
        burst_mode     <= (next_ctrl[`WORD_SIZE_HI:`WORD_SIZE_LO] == `WORD_SIZE_DWORD) &&
                          (next_ctrl[`TRANSFER_COUNT_HI:`TRANSFER_COUNT_LO] == `BURST_COUNT);
        // Write direction not handled here: a write request just stops the engine
        if (next_ctrl[`ACCESS_CONTROL_BIT] && !next_ctrl[`DIRECTION_BIT]) begin
          access_control_bit <= 1'b1;
          state              <= ST_BUS;
        end else begin
          access_control_bit <= 1'b0;
          state              <= ST_IDLE;
        end
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (rd_data && burst_done) begin
              read_ptr       <= read_ptr + 3'h1;
              access_ready_n <= 1'b1;
            end else if (rd_data) begin
              access_ready_n <= 1'b1;
            end
          end
          ST_BUS: begin
            if (bus_in.ack && bus_in.err) begin
              access_control_bit <= 1'b0;
              err_bit            <= 1'b1;
              err_event          <= 1'b1;
              access_ready_n     <= 1'b1;
              state              <= ST_IDLE;
            end else if (bus_in.ack) begin
              cur_addr  <= cur_addr + step;
              cur_count <= cur_count - `ONE_COUNT;
              if (burst_mode) begin
                beat <= beat + 2'h1;
                if (cur_count == `ONE_COUNT) begin
                  burst_done         <= 1'b1;
                  data_valid_bit     <= 1'b1;
                  access_ready_n     <= 1'b0;
                  access_control_bit <= 1'b0;
                  state              <= ST_IDLE;
                end else begin
                  state <= ST_STEP;
                end
              end else begin
                access_data    <= bus_in.rdata[31:0];
                access_ready_n <= 1'b0;
                if (cur_count == `ONE_COUNT) begin
                  data_valid_bit     <= 1'b1;
                  access_control_bit <= 1'b0;
                  state              <= ST_IDLE;
                end else begin
                  state <= ST_HOLD;
                end
              end
            end
          end
          ST_STEP: begin
            state <= ST_BUS;
          end
          ST_HOLD: begin
            // Next beat only after the tool has taken the current word
            if (rd_data) begin
              access_ready_n <= 1'b1;
              state          <= ST_BUS;
            end
          end
        endcase
      end
    end
  end

  // Link clock sampling; first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_sync  <= 3'h0;
      link_level <= 1'b0;
    end else if (ce) begin
      link_sync <= {link_sync[1:0], link_clk};
      if (link_sync[2] == link_sync[1]) begin
        link_level <= link_sync[2];
      end
    end
  end

  assign link_rise = (link_sync[2] == link_sync[1]) && link_sync[2] && !link_level;

  // Error message on the trace port, paced by the link clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trace_pending <= 1'b0;
      trace_phase   <= 1'b0;
      trace.mdo     <= 12'h000;
      trace.mseo    <= `MSEO_IDLE;
    end else if (ce) begin
      if (err_event) begin
        trace_pending <= 1'b1;
      end else if (link_rise && !trace_phase && trace_pending) begin
        trace_pending <= 1'b0;
      end
      if (link_rise) begin
        if (trace_phase) begin
          trace.mdo   <= {9'h000, err_frame[14:12]};
          trace.mseo  <= `MSEO_IDLE;
          trace_phase <= 1'b0;
        end else if (trace_pending) begin
          trace.mdo   <= err_frame[11:0];
          trace.mseo  <= `MSEO_START;
          trace_phase <= 1'b1;
        end else begin
          trace.mseo <= `MSEO_IDLE;
        end
      end
    end
  end

endmodule // debug_memory_access_engine

// ==== dmae_sva.sv ====
`timescale 1ns/1ps
`include "debug_memory_access_engine_map.svh"
module dmae_sva
  import dmae_pkg::*;
#(
  parameter logic [3:0] SOURCE_ID = 4'h5
) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         reset_n,
  // System bus
  input wire bus_request_t bus_out,
  input wire bus_answer_t  bus_in,
  // Trace and ready
  input wire trace_port_t  trace,
  input wire logic         access_ready_n
);
  localparam logic [14:0] FRAME = {`ERROR_CODE_RW, SOURCE_ID, `TCODE_RW_ERR};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_req_held: assert property (bus_out.req && !bus_in.ack |=>
    bus_out.req && $stable(bus_out.addr)) else $error("bus request dropped early");
  a_ready_clean: assert property ($fell(access_ready_n) |->
    $past(bus_in.ack) && !$past(bus_in.err)) else $error("ready without clean beat");
  a_err_quiet: assert property (bus_in.ack && bus_in.err |=> access_ready_n [*2])
    else $error("ready after bus error");
  a_err_message: assert property (bus_in.ack && bus_in.err |->
    ##[1:120] trace.mseo == `MSEO_START) else $error("no error message");
  a_frame_first: assert property (trace.mseo == `MSEO_START |->
    trace.mdo == FRAME[11:0]) else $error("bad first packet");
  a_frame_end: assert property ($changed(trace.mseo) && trace.mseo == `MSEO_IDLE |->
    trace.mdo == {9'h000, FRAME[14:12]}) else $error("bad last packet");
  a_mseo_legal: assert property (trace.mseo == `MSEO_IDLE || trace.mseo == `MSEO_START)
    else $error("bad framing pins");
  a_busy_not_ready: assert property (bus_out.req |-> access_ready_n)
    else $error("ready while bus busy");
  c_ready: cover property ($fell(access_ready_n));
  c_error: cover property (bus_in.ack && bus_in.err);
  c_frame: cover property (trace.mseo == `MSEO_START);
endmodule // dmae_sva

bind debug_memory_access_engine dmae_sva #(.SOURCE_ID(SOURCE_ID)) u_sva (.clk(clk),
  .reset_n(reset_n), .bus_out(bus_out), .bus_in(bus_in), .trace(trace),
  .access_ready_n(access_ready_n));

// ==== sys_bus_model.sv ====
`timescale 1ns/1ps
module sys_bus_model
  import dmae_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // System bus
  input  wire bus_request_t bus_out,
  output bus_answer_t       bus_in
);
  logic [1:0] wait_cnt;
  logic       slow;
  // Alternate prompt and slow answers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_in   <= '0;
      wait_cnt <= 2'h0;
      slow     <= 1'b0;
    end else begin
      bus_in.ack   <= 1'b0;
      bus_in.err   <= 1'b0;
      // Idle data churns so a late capture never matches
      bus_in.rdata <= {bus_in.rdata[62:0], ~bus_in.rdata[63]};
      if (bus_out.req && !bus_in.ack) begin
        if (wait_cnt == {slow, 1'b0}) begin
          bus_in.ack   <= 1'b1;
          bus_in.err   <= (bus_out.addr[31:28] == 4'hE);
          bus_in.rdata <= {~bus_out.addr, bus_out.addr};
          wait_cnt     <= 2'h0;
          slow         <= ~slow;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule // sys_bus_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "debug_memory_access_engine_map.svh"
module tb_top
  import dmae_pkg::*;
;
  localparam logic [3:0]  SOURCE_VAL = 4'hA; // Arbitrary value
  localparam logic [14:0] FRAME = {`ERROR_CODE_RW, SOURCE_VAL, `TCODE_RW_ERR};
  localparam logic [7:0]  CC    = {`IDX_CONTROL, 2'b00};
  localparam logic [7:0]  CA    = {`IDX_ADDRESS, 2'b00};
  localparam logic [7:0]  CD    = {`IDX_DATA, 2'b00};
  logic         clk = 0, reset_n = 0, ce = 1, link_clk = 0, link_en = 0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0, rdata, v;
  logic [3:0]   wstrb = 4'hF;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic         awready, wready, bvalid, arready, rvalid, access_ready_n;
  logic [1:0]   bresp, rresp, r;
  bus_request_t bus_out;
  bus_answer_t  bus_in;
  trace_port_t  trace;
  int           fail_count = 0, cmp_count = 0, acks = 0, cyc = 0, a0;

  debug_memory_access_engine #(.SOURCE_ID(SOURCE_VAL)) dut (.clk(clk), .reset_n(reset_n),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus_out(bus_out),
    .bus_in(bus_in), .link_clk(link_clk), .trace(trace), .access_ready_n(access_ready_n));
  sys_bus_model u_mem (.clk(clk), .reset_n(reset_n), .bus_out(bus_out), .bus_in(bus_in));

  always #2 clk = ~clk;
  // Link clock stands still outside error messages
  always #80 if (link_en) link_clk = ~link_clk;
  always @(posedge clk) begin
    if (bus_in.ack === 1'b1) acks++;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] ctl(input logic ac, input logic [2:0] sz, input int c);
    ctl = {ac, 1'b0, sz, 11'h0, 14'(c), 2'h0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin ad = 1; awvalid <= 0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge clk);
  endtask
  // Tool side paces each single and block data read on the ready pin; the burst words follow one wait
  task automatic wait_rdy();
    for (int n = 0; n < 300 && access_ready_n !== 1'b0; n++) @(posedge clk);
    chk("ready pin", 32'h0, 32'(access_ready_n));
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1;
    rd(CC, v); chk("control reset", `CTRL_RESET, v);
    chk("read response", 32'(`RESP_OKAY), 32'(r));
    rd(8'h00, v); chk("unmapped read", 32'(`RESP_DECERR), 32'(r));
    wr(8'h04, 32'h1); chk("unmapped write", 32'(`RESP_DECERR), 32'(r));
    // Clock enable low must refuse every new handshake
    ce <= 0;
    repeat (2) @(posedge clk);
    chk("frozen handshakes", 32'h0, 32'({awready, wready, arready}));
    ce <= 1;
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      a0 = acks;
      wr(CA, 32'h100 * (c + 1));
      chk("write response", 32'(`RESP_OKAY), 32'(r));
      wr(CC, ctl(1, 2, c));
      wait_rdy();
      rd(CD, v); chk("single data", 32'h100 * (c + 1), v);
      rd(CC, v); chk("single status", ctl(0, 2, c) | 32'h1, v);
      chk("single beats", 32'h1, 32'(acks - a0));
    end
    $display("test single done");
    a0 = acks;
    wr(CA, 32'h200); wr(CC, ctl(1, 2, 3));
    for (int i = 0; i < 3; i++) begin
      wait_rdy();
      rd(CD, v); chk("block data", 32'h200 + 4 * i, v);
      rd(CA, v); chk("address kept", 32'h200, v);
    end
    rd(CC, v); chk("block status", ctl(0, 2, 3) | 32'h1, v);
    chk("block beats", 32'h3, 32'(acks - a0));
    $display("test block done");
    a0 = acks;
    wr(CA, 32'h400); wr(CC, ctl(1, 3, 4));
    wait_rdy();
    chk("burst beats", 32'h4, 32'(acks - a0));
    rd(CC, v); chk("burst status", ctl(0, 3, 4) | 32'h1, v);
    for (int i = 0; i < 8; i++) begin
      rd(CD, v); chk("burst word", i[0] ? ~(32'h400 + 8 * (i / 2)) : 32'h400 + 8 * (i / 2), v);
    end
    $display("test burst done");
    a0 = acks;
    wr(CA, 32'h300); wr(CC, ctl(1, 2, 3));
    wait_rdy();
    wr(CA, 32'h500); wr(CC, ctl(1, 2, 0));
    wait_rdy();
    rd(CD, v); chk("restart data", 32'h500, v);
    chk("restart beats", 32'h2, 32'(acks - a0));
    wr(CA, 32'h600); wr(CC, ctl(1, 2, 3));
    wait_rdy();
    a0 = acks;
    wr(CC, ctl(0, 2, 3));
    repeat (20) @(posedge clk);
    chk("stop beats", 32'h0, 32'(acks - a0));
    rd(CC, v); chk("stop status", ctl(0, 2, 3), v);
    $display("test termination done");
    link_en = 1;
    wr(CA, 32'hE000_0000); wr(CC, ctl(1, 2, 0));
    for (int n = 0; n < 50 && v[`ERR_BIT] !== 1'b1; n++) rd(CC, v);
    chk("error status", ctl(0, 2, 0) | 32'h2, v);
    chk("error ready", 32'h1, 32'(access_ready_n));
    for (int n = 0; n < 300 && trace.mseo !== `MSEO_START; n++) @(posedge clk);
    chk("trace first", 32'(FRAME[11:0]), 32'(trace.mdo));
    for (int n = 0; n < 300 && trace.mseo !== `MSEO_IDLE; n++) @(posedge clk);
    chk("trace last", 32'(FRAME[14:12]), 32'(trace.mdo));
    link_en = 0;
    $display("test error done");
    report_and_stop();
  end
endmodule // tb_top
